// *** core/rcb_color_bank.sv ***
// Decided for this implementation: the address map and the address-and-strobe port.
module rcb_color_bank
	import rcb_pkg::*;
#(
	parameter int IDLE_CYCLES = SAVE_IDLE_CYCLES
)
(
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [7:0] RDATA_OUT,
	output logic [NUM_CH-1:0] LED_OUT,
	output logic POWER_SAVE_OUT
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] config_reg;
	logic [NUM_CH-1:0] group_follow_select;
	logic [7:0] bank_color [NUM_BANK_POS];
	logic [7:0] bank_intensity;
	logic [7:0] module_intensity_value [NUM_MODULES];
	logic [7:0] channel_color_value [NUM_CH];
	logic [7:0] next_config_reg;
	logic [NUM_CH-1:0] next_group_follow_select;
	logic [7:0] next_bank_color [NUM_BANK_POS];
	logic [7:0] next_bank_intensity;
	logic [7:0] next_module_intensity_value [NUM_MODULES];
	logic [7:0] next_channel_color_value [NUM_CH];
	logic [7:0] next_rdata;
	logic [15:0] follow_word;

	// ----------------------------------------
	// Period counter, power save
	// ----------------------------------------
	logic [7:0] pwm_count;
	logic [7:0] next_pwm_count;
	logic period_start;
	rcb_mode_t mode;
	rcb_mode_t next_mode;
	logic [SAVE_CNT_W-1:0] idle_count;
	logic [SAVE_CNT_W-1:0] next_idle_count;
	logic [NUM_CH-1:0] ch_pwm;
	logic [NUM_BANK_POS-1:0] bank_pwm;
	logic [7:0] bank_curved;

	assign follow_word = {{(16 - NUM_CH){1'b0}}, group_follow_select};

	// Intensity curve: linear, or exponent/mantissa approximation of a log curve
	function automatic logic [7:0] curve(input logic [7:0] v, input logic log_en);
		logic [12:0] shifted;
		shifted = 13'({1'b1, v[4:0]}) << v[7:5];
		if (!log_en || v == 8'h00)
		begin
			curve = v;
		end
		else
		begin
			curve = shifted[12:5];
		end
	endfunction : curve

	// Register writes and read data
	always_comb
	begin
		next_config_reg = config_reg;
		next_group_follow_select = group_follow_select;
		next_bank_color = bank_color;
		next_bank_intensity = bank_intensity;
		next_module_intensity_value = module_intensity_value;
		next_channel_color_value = channel_color_value;
		next_rdata = 8'h00;
		if (WR_IN)
		begin
			if (ADDR_IN == ADDR_CONFIG)
			begin
				next_config_reg = {6'h00, WDATA_IN[1:0]};
			end
			else if (ADDR_IN == ADDR_FOLLOW_LO)
			begin
				next_group_follow_select[7:0] = WDATA_IN;
			end
			else if (ADDR_IN == ADDR_FOLLOW_HI)
			begin
				next_group_follow_select[NUM_CH-1:8] = WDATA_IN[NUM_CH-9:0];
			end
			else if (ADDR_IN >= ADDR_BANK_COLOR0 && ADDR_IN < ADDR_BANK_INTENSITY)
			begin
				next_bank_color[2'(ADDR_IN - ADDR_BANK_COLOR0)] = WDATA_IN;
			end
			else if (ADDR_IN == ADDR_BANK_INTENSITY)
			begin
				next_bank_intensity = WDATA_IN;
			end
			else if (ADDR_IN >= ADDR_MOD_INTENSITY0 && ADDR_IN < ADDR_CH_COLOR0)
			begin
				next_module_intensity_value[2'(ADDR_IN - ADDR_MOD_INTENSITY0)] = WDATA_IN;
			end
			else if (ADDR_IN >= ADDR_CH_COLOR0 && ADDR_IN < ADDR_CH_COLOR0 + 8'(NUM_CH))
			begin
				next_channel_color_value[4'(ADDR_IN - ADDR_CH_COLOR0)] = WDATA_IN;
			end
		end
		if (RD_IN)
		begin
			if (ADDR_IN == ADDR_CONFIG)
			begin
				next_rdata = config_reg;
			end
			else if (ADDR_IN == ADDR_STATUS)
			begin
				next_rdata = {7'h00, mode == RCB_SAVE};
			end
			else if (ADDR_IN == ADDR_FOLLOW_LO)
			begin
				next_rdata = follow_word[7:0];
			end
			else if (ADDR_IN == ADDR_FOLLOW_HI)
			begin
				next_rdata = follow_word[15:8];
			end
			else if (ADDR_IN >= ADDR_BANK_COLOR0 && ADDR_IN < ADDR_BANK_INTENSITY)
			begin
				next_rdata = bank_color[2'(ADDR_IN - ADDR_BANK_COLOR0)];
			end
			else if (ADDR_IN == ADDR_BANK_INTENSITY)
			begin
				next_rdata = bank_intensity;
			end
			else if (ADDR_IN >= ADDR_MOD_INTENSITY0 && ADDR_IN < ADDR_CH_COLOR0)
			begin
				next_rdata = module_intensity_value[2'(ADDR_IN - ADDR_MOD_INTENSITY0)];
			end
			else if (ADDR_IN >= ADDR_CH_COLOR0 && ADDR_IN < ADDR_CH_COLOR0 + 8'(NUM_CH))
			begin
				next_rdata = channel_color_value[4'(ADDR_IN - ADDR_CH_COLOR0)];
			end
		end
	end

	// Register file flops
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			config_reg <= CONFIG_RESET;
			group_follow_select <= FOLLOW_RESET;
			bank_color <= '{default: VALUE_RESET};
			bank_intensity <= VALUE_RESET;
			module_intensity_value <= '{default: VALUE_RESET};
			channel_color_value <= '{default: VALUE_RESET};
			RDATA_OUT <= 8'h00;
		end
		else
		begin
			config_reg <= next_config_reg;
			group_follow_select <= next_group_follow_select;
			bank_color <= next_bank_color;
			bank_intensity <= next_bank_intensity;
			module_intensity_value <= next_module_intensity_value;
			channel_color_value <= next_channel_color_value;
			RDATA_OUT <= next_rdata;
		end
	end

	// ----------------------------------------
	// PWM paths
	// ----------------------------------------

	// Shared period counter
	always_comb
	begin
		next_pwm_count = (pwm_count == PWM_LAST) ? 8'h00 : pwm_count + 8'h01;
		period_start = (pwm_count == PWM_LAST);
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			pwm_count <= 8'h00;
		end
		else
		begin
			pwm_count <= next_pwm_count;
		end
	end

	assign bank_curved = curve(bank_intensity, config_reg[CFG_LOG_SCALE_BIT]);

	// Channel paths and bank paths, then the follow-select mux
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++)
		begin : g_ch
			rcb_pwm_path u_path (
				.clk_in(SYS_CLK_IN),
				.rst_in(RST_IN),
				.color_in(channel_color_value[gi]),
				.intensity_in(curve(module_intensity_value[gi / 3],
					config_reg[CFG_LOG_SCALE_BIT])),
				.count_in(pwm_count),
				.period_start_in(period_start),
				.pwm_out(ch_pwm[gi])
			);
			assign LED_OUT[gi] = group_follow_select[gi] ? bank_pwm[gi % 3] : ch_pwm[gi];
		end
		for (gi = 0; gi < NUM_BANK_POS; gi++)
		begin : g_bank
			rcb_pwm_path u_path (
				.clk_in(SYS_CLK_IN),
				.rst_in(RST_IN),
				.color_in(bank_color[gi]),
				.intensity_in(bank_curved),
				.count_in(pwm_count),
				.period_start_in(period_start),
				.pwm_out(bank_pwm[gi])
			);
		end
	endgenerate

	// ----------------------------------------
	// Power save
	// ----------------------------------------

	// Idle timer and mode; bus access wakes the device
	always_comb
	begin
		next_mode = mode;
		next_idle_count = idle_count;
		if (LED_OUT != '0 || WR_IN || RD_IN)
		begin
			next_idle_count = '0;
		end
		else if (idle_count < SAVE_CNT_W'(IDLE_CYCLES))
		begin
			next_idle_count = idle_count + 1'b1;
		end
		if (WR_IN || RD_IN)
		begin
			next_mode = RCB_NORMAL;
		end
		else if (config_reg[CFG_SAVE_EN_BIT] && LED_OUT == '0 &&
			idle_count >= SAVE_CNT_W'(IDLE_CYCLES))
		begin
			next_mode = RCB_SAVE;
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			mode <= RCB_NORMAL;
			idle_count <= '0;
		end
		else
		begin
			mode <= next_mode;
			idle_count <= next_idle_count;
		end
	end

	assign POWER_SAVE_OUT = (mode == RCB_SAVE);

endmodule : rcb_color_bank

// *** core/rcb_pkg.sv ***
package rcb_pkg;

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	localparam int NUM_MODULES = 4;
	localparam int NUM_CH = NUM_MODULES * 3;
	localparam int NUM_BANK_POS = 3;

	// ----------------------------------------
	// Register offsets (8-bit index space)
	// ----------------------------------------
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h01;
	localparam logic [7:0] ADDR_FOLLOW_LO = 8'h02;
	localparam logic [7:0] ADDR_FOLLOW_HI = 8'h03;
	localparam logic [7:0] ADDR_BANK_COLOR0 = 8'h04;
	localparam logic [7:0] ADDR_BANK_INTENSITY = 8'h07;
	localparam logic [7:0] ADDR_MOD_INTENSITY0 = 8'h08;
	localparam logic [7:0] ADDR_CH_COLOR0 = 8'h0C;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int CFG_LOG_SCALE_BIT = 0;
	localparam int CFG_SAVE_EN_BIT = 1;
	localparam int STAT_SAVE_BIT = 0;
	localparam logic [7:0] CONFIG_RESET = 8'h02;
	localparam logic [7:0] VALUE_RESET = 8'h00;
	localparam logic [NUM_CH-1:0] FOLLOW_RESET = '0;

	// ----------------------------------------
	// PWM period: counter runs 0 .. PWM_LAST
	// ----------------------------------------
	localparam logic [7:0] PWM_LAST = 8'hFE;

	// ----------------------------------------
	// Power-save timing
	// ----------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int SAVE_IDLE_MS = 30;
	localparam int SAVE_IDLE_CYCLES = (CLK_HZ / 1000) * SAVE_IDLE_MS;
	localparam int SAVE_CNT_W = 20;

	// Power-save states
	typedef enum logic {RCB_NORMAL, RCB_SAVE} rcb_mode_t;

endpackage : rcb_pkg

// *** core/rcb_pwm_path.sv ***
// ----------------------------------------
// One PWM path: color times intensity, compared to the period counter
// ----------------------------------------
module rcb_pwm_path
	import rcb_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [7:0] color_in,
	input wire logic [7:0] intensity_in,
	input wire logic [7:0] count_in,
	input wire logic period_start_in,
	output logic pwm_out
);

	logic [7:0] duty;
	logic [7:0] next_duty;
	logic next_pwm;
	logic [15:0] product;

	// Duty from product, loaded only at period start to avoid glitches
	always_comb
	begin
		product = color_in * intensity_in;
		next_duty = duty;
		if (period_start_in)
		begin
			next_duty = product[15:8] + {7'h00, |product[7:0]};
		end
		next_pwm = (count_in < next_duty);
	end

	// Registers
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			duty <= 8'h00;
			pwm_out <= 1'b0;
		end
		else
		begin
			duty <= next_duty;
			pwm_out <= next_pwm;
		end
	end

endmodule : rcb_pwm_path

// *** tb/rcb_asserts.sv ***
// ----------------------------------------
// Port checker for the color bank block
// ----------------------------------------
module rcb_asserts
	import rcb_pkg::*;
#(
	parameter int IDLE_CYCLES = SAVE_IDLE_CYCLES
)
(
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [7:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [7:0] RDATA_OUT,
	input wire logic [NUM_CH-1:0] LED_OUT,
	input wire logic POWER_SAVE_OUT
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] shadow [24];
	int quiet;

	// Shadow of writable values and a count of dark, bus-quiet cycles
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN)
	begin
		if (RST_IN)
		begin
			shadow <= '{0: CONFIG_RESET, default: VALUE_RESET};
			quiet <= 0;
		end
		else
		begin
			if (WR_IN && ADDR_IN < 8'h18 && ADDR_IN != ADDR_STATUS)
			begin
				shadow[ADDR_IN[4:0]] <= WDATA_IN & ((ADDR_IN == ADDR_CONFIG) ? 8'h03 :
					(ADDR_IN == ADDR_FOLLOW_HI) ? 8'h0F : 8'hFF);
			end
			quiet <= (WR_IN || RD_IN || LED_OUT != '0) ? 0 : quiet + 1;
		end
	end

	default clocking cb @(posedge SYS_CLK_IN);
	endclocking
	default disable iff (RST_IN);

	rd_idle_zero_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
		else $error("read data not cleared");
	rd_unmapped_a: assert property (RD_IN && ADDR_IN > 8'h17 |=> RDATA_OUT == 8'h00)
		else $error("unmapped read not zero");
	rd_back_a: assert property (RD_IN && ADDR_IN < 8'h18 && ADDR_IN != ADDR_STATUS
		|=> RDATA_OUT == shadow[$past(ADDR_IN)]) else $error("read back differs");
	wake_strobe_a: assert property (POWER_SAVE_OUT && (WR_IN || RD_IN) |=> !POWER_SAVE_OUT)
		else $error("no wake on access");
	save_holds_a: assert property (POWER_SAVE_OUT && !WR_IN && !RD_IN |=> POWER_SAVE_OUT)
		else $error("save left without access");
	save_dark_a: assert property ($rose(POWER_SAVE_OUT) |-> $past(LED_OUT) == '0)
		else $error("save entered with lit output");
	save_quiet_a: assert property ($rose(POWER_SAVE_OUT) |-> quiet >= IDLE_CYCLES)
		else $error("save entered too early");
	save_enabled_a: assert property ($rose(POWER_SAVE_OUT) |-> shadow[0][CFG_SAVE_EN_BIT])
		else $error("save entered while disabled");
	save_entry_a: assert property (quiet == IDLE_CYCLES + 2 && shadow[0][1] |-> POWER_SAVE_OUT)
		else $error("save not entered");

	cover property ($rose(POWER_SAVE_OUT));
	cover property (POWER_SAVE_OUT && RD_IN);
	cover property (RD_IN && ADDR_IN == ADDR_CH_COLOR0);
endmodule : rcb_asserts

bind rcb_color_bank rcb_asserts #(.IDLE_CYCLES(IDLE_CYCLES)) chk (.SYS_CLK_IN(SYS_CLK_IN),
	.RST_IN(RST_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
	.RDATA_OUT(RDATA_OUT), .LED_OUT(LED_OUT), .POWER_SAVE_OUT(POWER_SAVE_OUT));

// *** tb/rcb_host.sv ***
// ----------------------------------------
// Host controller model: register bus master
// ----------------------------------------
module rcb_host
	import rcb_pkg::*;
(
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out = 8'h00,
	output logic [7:0] wdata_out = 8'h00,
	output logic wr_out = 1'b0,
	output logic rd_out = 1'b0
);
	timeunit 1ns;
	timeprecision 1ns;

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask : wr

	// One-cycle read strobe, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		#1;
		d = rdata_in;
	endtask : rd
endmodule : rcb_host

// *** tb/rcb_color_bank_tb.sv ***
module rcb_color_bank_tb
	import rcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int IDLE = 50;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	wire logic [7:0] addr, wdata, rdata;
	wire logic wr, rd, save;
	wire logic [NUM_CH-1:0] led;
	int bad_count = 0;
	int check_count = 0;
	logic [31:0] seed = 32'hECC24E56;
	logic [7:0] col [NUM_CH];
	logic [7:0] gint [NUM_MODULES];
	logic [7:0] bcol [NUM_BANK_POS];
	logic [7:0] bint;
	logic [NUM_CH-1:0] fol;
	logic lg;
	logic [7:0] rv;
	int hi [NUM_CH];

	rcb_color_bank #(.IDLE_CYCLES(IDLE)) dut (.SYS_CLK_IN(sys_clk), .RST_IN(rst), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .LED_OUT(led),
		.POWER_SAVE_OUT(save));
	rcb_host host (.clk_in(sys_clk), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	// Expected high cycles per period for channel i
	function automatic int duty(input int i);
		int c;
		int n;
		c = fol[i] ? bcol[i % 3] : col[i];
		n = fol[i] ? bint : gint[i / 3];
		if (lg && n != 0)
		begin
			n = ((32 + n % 32) << (n / 32)) >> 5;
		end
		return (c * n + 255) >> 8;
	endfunction : duty

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
		begin
			$display("ALL TESTS PASSED");
		end
		else
		begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : summarize

	// Random values everywhere, full scale on channel 0 and group 0
	task automatic program_all(input logic [7:0] cfg, input logic [NUM_CH-1:0] f);
		host.wr(ADDR_CONFIG, cfg);
		lg = cfg[CFG_LOG_SCALE_BIT];
		fol = f;
		for (int i = 0; i < NUM_CH; i++)
		begin
			col[i] = (i == 0) ? 8'hFF : rnd();
			host.wr(ADDR_CH_COLOR0 + 8'(i), col[i]);
		end
		for (int g = 0; g < NUM_MODULES; g++)
		begin
			gint[g] = (g == 0) ? 8'hFF : rnd();
			host.wr(ADDR_MOD_INTENSITY0 + 8'(g), gint[g]);
		end
		for (int b = 0; b < NUM_BANK_POS; b++)
		begin
			bcol[b] = rnd();
			host.wr(ADDR_BANK_COLOR0 + 8'(b), bcol[b]);
		end
		bint = rnd();
		host.wr(ADDR_BANK_INTENSITY, bint);
		host.wr(ADDR_FOLLOW_LO, f[7:0]);
		host.wr(ADDR_FOLLOW_HI, {4'h0, f[11:8]});
	endtask : program_all

	// Count high cycles over one full period after settling
	task automatic measure();
		repeat (510) @(negedge sys_clk);
		hi = '{default: 0};
		repeat (255)
		begin
			@(negedge sys_clk);
			for (int i = 0; i < NUM_CH; i++)
			begin
				hi[i] += led[i];
			end
		end
		for (int i = 0; i < NUM_CH; i++)
		begin
			check(16'(hi[i]), 16'(duty(i)));
		end
	endtask : measure

	// ----------------------------------------
	// Clock, watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		forever #50 sys_clk = ~sys_clk;
	end

	initial
	begin
		#(20000 * 100);
		bad_count++;
		summarize();
	end

	initial
	begin
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		host.rd(ADDR_CONFIG, rv);
		check(16'(rv), 16'(CONFIG_RESET));
		host.rd(ADDR_FOLLOW_LO, rv);
		check(16'(rv), 16'(FOLLOW_RESET[7:0]));
		host.rd(8'h7F, rv);
		check(16'(rv), 16'h0000);
		program_all(8'h02, '0);
		for (int i = 0; i < NUM_CH; i++)
		begin
			host.rd(ADDR_CH_COLOR0 + 8'(i), rv);
			check(16'(rv), 16'(col[i]));
		end
		measure();
		program_all(8'h03, '0);
		measure();
		program_all(8'h02, {4'(rnd()), rnd()});
		measure();
		for (int g = 0; g < NUM_MODULES; g++)
		begin
			host.wr(ADDR_MOD_INTENSITY0 + 8'(g), 8'h00);
		end
		host.wr(ADDR_BANK_INTENSITY, 8'h00);
		repeat (255 + IDLE + 10) @(negedge sys_clk);
		check(16'(save), 16'h0001);
		check(16'(led), 16'h0000);
		host.rd(ADDR_STATUS, rv);
		check(16'(rv), 16'h0001);
		@(negedge sys_clk);
		check(16'(save), 16'h0000);
		host.wr(ADDR_CONFIG, 8'h00);
		repeat (IDLE + 20) @(negedge sys_clk);
		check(16'(save), 16'h0000);
		summarize();
	end
endmodule : rcb_color_bank_tb
